// ### nsspr_cfg.svh
// Register offsets, field positions, reset values and counts for the NCO sync and SERDES power bank.
`ifndef NSSPR_CFG_SVH
`define NSSPR_CFG_SVH

// Register offsets on the serial control port register space.
`define NSSPR_OFS_CAL_MODE 12'h1e6
`define NSSPR_OFS_SYNC_CFG 12'h1e7
`define NSSPR_OFS_RECEIVER_MASTER_POWERDOWN 12'h200
`define NSSPR_OFS_LANE_PD 12'h201
`define NSSPR_OFS_SYNCOUT_PD 12'h203
`define NSSPR_OFS_LANE_RECOVERY_RESET 12'h206
`define NSSPR_OFS_CFG_ADDR 12'h210
`define NSSPR_OFS_LANE_STROBE 12'h212
`define NSSPR_OFS_MISC_STROBE 12'h213
`define NSSPR_OFS_CFG_DATA 12'h216

// Field positions.
`define NSSPR_BIT_CAL_TUNE 0
`define NSSPR_BIT_CAL_DC 1
`define NSSPR_BIT_SYNC_START 0
`define NSSPR_BIT_SYNC_ACK 1
`define NSSPR_BIT_SYNC_OUTPUT1_PINS_PD 0
`define NSSPR_BIT_SYNC_OUTPUT0_PINS_PD 1

// Reset values.
`define NSSPR_RST_RECEIVER_MASTER_POWERDOWN 8'h01
`define NSSPR_RST_LANE_PD 8'hee
`define NSSPR_RST_SYNCOUT_PD 8'h01
`define NSSPR_RST_ZERO 8'h00

// Counts.
`define NSSPR_NUM_DAC 2
`define NSSPR_NUM_LANE 8

`endif

// ### nsspr_pkg.sv
// Types shared by the NCO sync and SERDES power register bank.
`default_nettype none
package nsspr_pkg;

	// Per-converter oscillator synchronisation sequence.
	typedef enum logic [1:0] {
		SYNC_IDLE,
		SYNC_LOAD,
		SYNC_ALIGN,
		SYNC_WAIT
	} nsspr_sync_state_t;

endpackage : nsspr_pkg
`default_nettype wire

// ### nsspr_regs.sv
// NCO sync, calibration mux, SERDES power-down and configuration bus commit registers.
`include "nsspr_cfg.svh"
`default_nettype none

module nsspr_regs #(
	parameter int DATA_W = 16
) (
	input wire logic clock_i, // Register clock.
	input wire logic rst_n_i, // Synchronous reset, active low.
	input wire logic [11:0] reg_addr_i, // Register address from control port.
	input wire logic reg_wr_i, // Write strobe, one cycle.
	input wire logic [7:0] reg_wdata_i, // Write data.
	input wire logic reg_rd_i, // Read strobe, one cycle.
	output logic [7:0] reg_rdata_o, // Read data, valid with reg_rvalid_o.
	output logic reg_rvalid_o, // Read answer pulse.
	input wire logic [1:0] main_converter_page_select_i, // Page bits held elsewhere.
	input wire logic trigger_is_sysref_i, // 1 selects SYSREF as update trigger.
	input wire logic sysref_i, // SYSREF level.
	input wire logic oscillator_reset_after_rotation_i, // Rotation reset enable level.
	input wire logic [1:0] nco_loaded_i, // Per converter, active oscillators loaded.
	input wire logic [1:0][DATA_W-1:0] datapath_i, // Datapath samples per converter.
	input wire logic [DATA_W-1:0] dc_value_i, // Dc level for the final DDS.
	output logic [1:0][DATA_W-1:0] dds_in_o, // Final DDS input per converter.
	output logic cal_frequency_tune_enable_o, // Calibration tuning, converter 0.
	output logic [1:0] ftw_load_o, // Tuning word load pulse per converter.
	output logic [1:0] phase_sync_o, // Phase sync pulse per converter.
	output logic receiver_master_powerdown_o, // Whole receiver power-down.
	output logic [7:0] lane_powerdown_o, // Per-lane power-down.
	output logic sync_output0_powerdown_o, // Sync output 0 driver power-down.
	output logic sync_output1_powerdown_o, // Sync output 1 driver power-down.
	output logic lane_recovery_reset_release_o, // 1 releases lane PHYs.
	output logic [7:0] serdes_config_addr_o, // Configuration bus address.
	output logic [7:0] serdes_config_data_o, // Configuration bus data.
	output logic [7:0] serdes_lane_commit_o, // Per-lane commit pulse.
	output logic serdes_misc_commit_o // Remaining logic commit pulse.
);

	////////////////////////////////////////////////////////////////////////////////
	// Address decode.

	function automatic logic nsspr_hit(input logic [11:0] addr, input logic [11:0] ofs);
		nsspr_hit = (addr == ofs);
	endfunction

	// Write enables per register.
	wire logic wr_cal = reg_wr_i && nsspr_hit(reg_addr_i, `NSSPR_OFS_CAL_MODE);
	wire logic wr_sync = reg_wr_i && nsspr_hit(reg_addr_i, `NSSPR_OFS_SYNC_CFG);
	wire logic wr_mpd = reg_wr_i && nsspr_hit(reg_addr_i, `NSSPR_OFS_RECEIVER_MASTER_POWERDOWN);
	wire logic wr_lpd = reg_wr_i && nsspr_hit(reg_addr_i, `NSSPR_OFS_LANE_PD);
	wire logic wr_spd = reg_wr_i && nsspr_hit(reg_addr_i, `NSSPR_OFS_SYNCOUT_PD);
	wire logic wr_cdr = reg_wr_i && nsspr_hit(reg_addr_i, `NSSPR_OFS_LANE_RECOVERY_RESET);
	wire logic wr_addr = reg_wr_i && nsspr_hit(reg_addr_i, `NSSPR_OFS_CFG_ADDR);
	wire logic wr_data = reg_wr_i && nsspr_hit(reg_addr_i, `NSSPR_OFS_CFG_DATA);
	wire logic wr_lstb = reg_wr_i && nsspr_hit(reg_addr_i, `NSSPR_OFS_LANE_STROBE);
	wire logic wr_mstb = reg_wr_i && nsspr_hit(reg_addr_i, `NSSPR_OFS_MISC_STROBE);

	// Trigger edges shared by both converters; inputs are already in this clock domain.
	logic sysref_prev;
	logic rot_prev;
	wire logic sysref_rise = sysref_i && !sysref_prev;
	wire logic rot_rise = oscillator_reset_after_rotation_i && !rot_prev;

	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			sysref_prev <= 1'b0;
			rot_prev <= 1'b0;
		end else begin
			sysref_prev <= sysref_i;
			rot_prev <= oscillator_reset_after_rotation_i;
		end
	end

	// Readback copies of the paged fields, gathered from the per-converter slices.
	wire logic [1:0] cal_dc_rb;
	wire logic [1:0] sync_start_rb;
	wire logic [1:0] sync_ack_rb;
	logic cal_tune;

	////////////////////////////////////////////////////////////////////////////////
	// Paged per-converter slice: calibration mux and oscillator sync sequence.

	for (genvar d = 0; d < `NSSPR_NUM_DAC; d++) begin : gen_dac
		logic cal_dc_select;
		logic sync_start;
		logic start_prev;
		logic sync_ack;
		nsspr_pkg::nsspr_sync_state_t state;
		nsspr_pkg::nsspr_sync_state_t next_state;
		logic [DATA_W-1:0] dds_in;
		logic ftw_load;
		logic phase_sync;
		wire logic page_on = main_converter_page_select_i[d];
		wire logic start_rise = sync_start && !start_prev;
		// The bit trigger and SYSREF are exclusive; rotation reset acks the same way.
		// SYSREF and rotation are device-wide events and start every idle converter;
		// only the start bit is paged; a converter busy in a sequence ignores them, as only SYNC_IDLE takes a trigger.
		wire logic trig = (trigger_is_sysref_i ? sysref_rise : start_rise) || rot_rise;

		// Paged control bits; only a page selected at write time takes the value.
		always_ff @(posedge clock_i) begin
			if (!rst_n_i) begin
				cal_dc_select <= 1'b0;
				sync_start <= 1'b0;
				start_prev <= 1'b0;
			end else begin
				if (wr_cal && page_on) begin
					cal_dc_select <= reg_wdata_i[`NSSPR_BIT_CAL_DC];
				end
				if (wr_sync && page_on) begin
					sync_start <= reg_wdata_i[`NSSPR_BIT_SYNC_START];
				end
				start_prev <= sync_start;
			end
		end

		// Final DDS input: datapath when the select is 0, dc when it is 1.
		always_ff @(posedge clock_i) begin
			if (!rst_n_i) begin
				dds_in <= '0;
			end else begin
				dds_in <= cal_dc_select ? dc_value_i : datapath_i[d];
			end
		end

		// Sequence: load tuning words, then align phase, then wait for the loaded report.
		always_comb begin
			next_state = state;
			unique case (state)
				nsspr_pkg::SYNC_IDLE: begin
					if (trig) begin
						next_state = nsspr_pkg::SYNC_LOAD;
					end
				end
				nsspr_pkg::SYNC_LOAD: begin
					next_state = nsspr_pkg::SYNC_ALIGN;
				end
				nsspr_pkg::SYNC_ALIGN: begin
					next_state = nsspr_pkg::SYNC_WAIT;
				end
				nsspr_pkg::SYNC_WAIT: begin
					if (nco_loaded_i[d]) begin
						next_state = nsspr_pkg::SYNC_IDLE;
					end
				end
			endcase
		end

		// Pulses are registered so that the outputs leave flip-flops directly.
		always_ff @(posedge clock_i) begin
			if (!rst_n_i) begin
				state <= nsspr_pkg::SYNC_IDLE;
				ftw_load <= 1'b0;
				phase_sync <= 1'b0;
				sync_ack <= 1'b0;
			end else begin
				state <= next_state;
				ftw_load <= (state == nsspr_pkg::SYNC_IDLE) && trig;
				phase_sync <= (state == nsspr_pkg::SYNC_LOAD);
				if (state == nsspr_pkg::SYNC_WAIT && nco_loaded_i[d]) begin
					sync_ack <= 1'b1;
				end else if (state == nsspr_pkg::SYNC_IDLE && trig) begin
					sync_ack <= 1'b0;
				end
			end
		end

		assign dds_in_o[d] = dds_in;
		assign ftw_load_o[d] = ftw_load;
		assign phase_sync_o[d] = phase_sync;
		assign cal_dc_rb[d] = cal_dc_select;
		assign sync_start_rb[d] = sync_start;
		assign sync_ack_rb[d] = sync_ack;
	end

	// Calibration tuning exists for converter 0 only, so only page 0 stores it.
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			cal_tune <= 1'b0;
		end else if (wr_cal && main_converter_page_select_i[0]) begin
			cal_tune <= reg_wdata_i[`NSSPR_BIT_CAL_TUNE];
		end
	end
	assign cal_frequency_tune_enable_o = cal_tune;

	////////////////////////////////////////////////////////////////////////////////
	// Receiver power-down, lane reset and sync output driver controls.

	// Reset images of the bit-wide registers; single bits are taken by position so
	// that no reset constant is cut to width by accident.
	localparam logic [7:0] RECEIVER_MASTER_POWERDOWN_RST = `NSSPR_RST_RECEIVER_MASTER_POWERDOWN;
	localparam logic [7:0] SYNCOUT_PD_RST = `NSSPR_RST_SYNCOUT_PD;

	// The receiver starts powered down, so nothing draws current before setup.
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			receiver_master_powerdown_o <= RECEIVER_MASTER_POWERDOWN_RST[0];
		end else if (wr_mpd) begin
			receiver_master_powerdown_o <= reg_wdata_i[0];
		end
	end

	// Lane overrides: bit n powers down serial lane n.
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			lane_powerdown_o <= `NSSPR_RST_LANE_PD;
		end else if (wr_lpd) begin
			lane_powerdown_o <= reg_wdata_i;
		end
	end

	// Sync output drivers: output 0 starts enabled, output 1 starts powered down.
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			sync_output0_powerdown_o <= SYNCOUT_PD_RST[`NSSPR_BIT_SYNC_OUTPUT0_PINS_PD];
			sync_output1_powerdown_o <= SYNCOUT_PD_RST[`NSSPR_BIT_SYNC_OUTPUT1_PINS_PD];
		end else if (wr_spd) begin
			sync_output0_powerdown_o <= reg_wdata_i[`NSSPR_BIT_SYNC_OUTPUT0_PINS_PD];
			sync_output1_powerdown_o <= reg_wdata_i[`NSSPR_BIT_SYNC_OUTPUT1_PINS_PD];
		end
	end

	// Lane PHYs stay in reset until the host writes 1.
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			lane_recovery_reset_release_o <= 1'b0;
		end else if (wr_cdr) begin
			lane_recovery_reset_release_o <= reg_wdata_i[0];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Indirect configuration bus: address, data and commit strobes.

	logic [7:0] lane_strobe;
	logic misc_strobe;
	logic [7:0] lane_prev;
	logic misc_prev;

	// Commit fires on the 0 to 1 change of a strobe bit, so a host must clear it
	// before the next commit; holding it high does not repeat the write.
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			serdes_config_addr_o <= `NSSPR_RST_ZERO;
			serdes_config_data_o <= `NSSPR_RST_ZERO;
			lane_strobe <= `NSSPR_RST_ZERO;
			misc_strobe <= 1'b0;
			lane_prev <= `NSSPR_RST_ZERO;
			misc_prev <= 1'b0;
			serdes_lane_commit_o <= `NSSPR_RST_ZERO;
			serdes_misc_commit_o <= 1'b0;
		end else begin
			if (wr_addr) begin
				serdes_config_addr_o <= reg_wdata_i;
			end
			if (wr_data) begin
				serdes_config_data_o <= reg_wdata_i;
			end
			if (wr_lstb) begin
				lane_strobe <= reg_wdata_i;
			end
			if (wr_mstb) begin
				misc_strobe <= reg_wdata_i[0];
			end
			lane_prev <= lane_strobe;
			misc_prev <= misc_strobe;
			serdes_lane_commit_o <= lane_strobe & ~lane_prev;
			serdes_misc_commit_o <= misc_strobe && !misc_prev;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Readback. Paged fields read from the lowest selected page.

	wire logic rd_idx = !main_converter_page_select_i[0];
	logic [7:0] rd_value;

	// Unmapped addresses and reserved bits return zero.
	always_comb begin
		rd_value = 8'h00;
		unique case (reg_addr_i)
			`NSSPR_OFS_CAL_MODE: begin
				rd_value = {6'h00, cal_dc_rb[rd_idx], cal_tune && !rd_idx};
			end
			`NSSPR_OFS_SYNC_CFG: begin
				rd_value = {6'h00, sync_ack_rb[rd_idx], sync_start_rb[rd_idx]};
			end
			`NSSPR_OFS_RECEIVER_MASTER_POWERDOWN: begin
				rd_value = {7'h00, receiver_master_powerdown_o};
			end
			`NSSPR_OFS_LANE_PD: begin
				rd_value = lane_powerdown_o;
			end
			`NSSPR_OFS_SYNCOUT_PD: begin
				rd_value = {6'h00, sync_output0_powerdown_o, sync_output1_powerdown_o};
			end
			`NSSPR_OFS_LANE_RECOVERY_RESET: begin
				rd_value = {7'h00, lane_recovery_reset_release_o};
			end
			`NSSPR_OFS_CFG_ADDR: begin
				rd_value = serdes_config_addr_o;
			end
			`NSSPR_OFS_CFG_DATA: begin
				rd_value = serdes_config_data_o;
			end
			`NSSPR_OFS_LANE_STROBE: begin
				rd_value = lane_strobe;
			end
			`NSSPR_OFS_MISC_STROBE: begin
				rd_value = {7'h00, misc_strobe};
			end
			default: begin
				rd_value = 8'h00;
			end
		endcase
	end

	// Read data is registered one cycle after the strobe.
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			reg_rdata_o <= 8'h00;
			reg_rvalid_o <= 1'b0;
		end else begin
			reg_rvalid_o <= reg_rd_i;
			reg_rdata_o <= reg_rd_i ? rd_value : 8'h00;
		end
	end

endmodule : nsspr_regs
`default_nettype wire

// ### nsspr_checker.sv
// Concurrent checks on the ports of the NCO sync and SERDES power bank.
`default_nettype none

//////////////////////////////////////////////////////////////////////
module nsspr_checker (
	input wire logic clock_i, // Register clock.
	input wire logic rst_n_i, // Reset, active low.
	input wire logic [11:0] reg_addr_i, // Register address.
	input wire logic reg_wr_i, // Write strobe.
	input wire logic [7:0] reg_wdata_i, // Write data.
	input wire logic [7:0] reg_rdata_o, // Read data.
	input wire logic reg_rvalid_o, // Read answer.
	input wire logic [1:0] ftw_load_o, // Tuning word load.
	input wire logic [1:0] phase_sync_o, // Phase sync.
	input wire logic receiver_master_powerdown_o, // Receiver off.
	input wire logic [7:0] lane_powerdown_o, // Lanes off.
	input wire logic sync_output1_powerdown_o, // Sync output 1 off.
	input wire logic [7:0] serdes_config_addr_o, // Config address.
	input wire logic serdes_misc_commit_o // Misc commit.
);
	// All checks share one clock, and reset cancels any check in flight.
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);

	// Values seen right after reset must leave the receiver safely off.
	AST_MASTER_RST: assert property ($rose(rst_n_i) |-> receiver_master_powerdown_o)
		else $error("master power-down not set after reset");
	AST_LANE_RST: assert property ($rose(rst_n_i) |-> lane_powerdown_o == 8'hee)
		else $error("lane power-down reset value wrong");
	AST_SYNC1_RST: assert property ($rose(rst_n_i) |-> sync_output1_powerdown_o)
		else $error("sync output 1 not off after reset");
	// Writes land on the next cycle with the exact written value.
	AST_LANE_WR: assert property (reg_wr_i && reg_addr_i == 12'h201
		|=> lane_powerdown_o == $past(reg_wdata_i))
		else $error("lane power-down write lost");
	AST_MASTER_WR: assert property (reg_wr_i && reg_addr_i == 12'h200
		|=> receiver_master_powerdown_o == $past(reg_wdata_i[0]))
		else $error("master power-down write lost");
	AST_ADDR_WR: assert property (reg_wr_i && reg_addr_i == 12'h210
		|=> serdes_config_addr_o == $past(reg_wdata_i))
		else $error("config address write lost");
	// Loading precedes the phase step: converter 0 checks that phase follows load, converter 1 that no phase comes without one.
	AST_PHASE: assert property (ftw_load_o[0] |=> phase_sync_o[0] && !ftw_load_o[0])
		else $error("phase sync did not follow load");
	AST_NO_EARLY: assert property (phase_sync_o[1] |-> $past(ftw_load_o[1]))
		else $error("phase sync without prior load");
	AST_MISC_PULSE: assert property (serdes_misc_commit_o |=> !serdes_misc_commit_o)
		else $error("misc commit longer than one cycle");
	AST_RSV: assert property (reg_rvalid_o && $past(reg_addr_i) == 12'h200
		|-> reg_rdata_o[7:1] == 7'h00)
		else $error("reserved bits not zero");
endmodule // nsspr_checker

bind nsspr_regs nsspr_checker i_nsspr_checker (.clock_i, .rst_n_i, .reg_addr_i, .reg_wr_i,
	.reg_wdata_i, .reg_rdata_o, .reg_rvalid_o, .ftw_load_o, .phase_sync_o,
	.receiver_master_powerdown_o, .lane_powerdown_o, .sync_output1_powerdown_o,
	.serdes_config_addr_o, .serdes_misc_commit_o);
`default_nettype wire

// ### nsspr_host.sv
// Host model that drives the register port of the bank.
`default_nettype none
module nsspr_host (
	input wire logic clock_i, // Register clock.
	output logic [11:0] addr_o, // Register address.
	output logic wr_o, // Write strobe.
	output logic [7:0] wdata_o, // Write data.
	output logic rd_o, // Read strobe.
	input wire logic [7:0] rdata_i, // Read data.
	input wire logic rvalid_i // Read answer.
);
	timeunit 1ns;
	timeprecision 100ps;

	// Bus idles with no request pending.
	initial begin
		wr_o = 1'b0;
		rd_o = 1'b0;
		addr_o = 12'h000;
		wdata_o = 8'h00;
	end

	// Idle lines show the inverse so a stale value never looks valid.
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge clock_i);
		#1;
		addr_o = a;
		wdata_o = d;
		wr_o = 1'b1;
		@(posedge clock_i);
		#1;
		wr_o = 1'b0;
		addr_o = ~a;
		wdata_o = ~d;
	endtask

	// The answer stands one cycle, so it is taken straight after the edge.
	task automatic rd(input logic [11:0] a, output logic [7:0] d);
		@(posedge clock_i);
		#1;
		addr_o = a;
		rd_o = 1'b1;
		@(posedge clock_i);
		#1;
		rd_o = 1'b0;
		addr_o = ~a;
		d = rvalid_i ? rdata_i : 8'hxx;
	endtask
endmodule // nsspr_host
`default_nettype wire

// ### tb_top.sv
// Self-checking bench for the NCO sync and SERDES power bank.
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic clock_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [11:0] reg_addr_i;
	logic reg_wr_i, reg_rd_i, reg_rvalid_o;
	logic [7:0] reg_wdata_i, reg_rdata_o, got;
	logic [1:0] main_converter_page_select = 2'b01;
	logic trigger_is_sysref_i = 1'b0, sysref_i = 1'b0, oscillator_reset_after_rotation = 1'b0;
	logic [1:0] nco_loaded_i = 2'b00, ftw_load_o, phase_sync_o;
	logic [1:0][15:0] datapath_i = '0, dds_in_o;
	logic [15:0] dc_value_i = 16'h0000;
	logic cal_frequency_tune_enable_o, receiver_master_powerdown_o, serdes_misc_commit_o;
	logic sync_output0_powerdown_o, sync_output1_powerdown_o, lane_recovery_reset_release_o;
	logic [7:0] lane_powerdown_o, serdes_config_addr_o, serdes_config_data_o, serdes_lane_commit_o;
	int bad_count = 0;
	int checked = 0;
	integer seed = 32'he6523fc0;
	int mdl[int];
	int msk[int];
	int adr[8] = '{12'h200, 12'h201, 12'h203, 12'h206, 12'h210, 12'h216, 12'h212, 12'h213};
	int rsv[8] = '{8'h01, 8'hee, 8'h01, 0, 0, 0, 0, 0};
	int mk[8] = '{8'h01, 8'hff, 8'h03, 8'h01, 8'hff, 8'hff, 8'hff, 8'h01};

	//////////////////////////////////////////////////////////////////
	// Clock, design and host.
	always #2.5 clock_i = ~clock_i;
	nsspr_regs i_nsspr_regs (.clock_i, .rst_n_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i,
		.reg_rd_i, .reg_rdata_o, .reg_rvalid_o,
		.main_converter_page_select_i(main_converter_page_select), .trigger_is_sysref_i,
		.sysref_i, .oscillator_reset_after_rotation_i(oscillator_reset_after_rotation),
		.nco_loaded_i,
		.datapath_i, .dc_value_i, .dds_in_o, .cal_frequency_tune_enable_o, .ftw_load_o,
		.phase_sync_o, .receiver_master_powerdown_o, .lane_powerdown_o,
		.sync_output0_powerdown_o, .sync_output1_powerdown_o, .lane_recovery_reset_release_o,
		.serdes_config_addr_o, .serdes_config_data_o, .serdes_lane_commit_o,
		.serdes_misc_commit_o);
	nsspr_host i_nsspr_host (.clock_i, .addr_o(reg_addr_i), .wr_o(reg_wr_i),
		.wdata_o(reg_wdata_i), .rd_o(reg_rd_i), .rdata_i(reg_rdata_o), .rvalid_i(reg_rvalid_o));

	//////////////////////////////////////////////////////////////////
	// Compare helpers and the single closing point.
	task automatic chk(input logic [35:0] g, input logic [35:0] e);
		checked++;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic rdchk(input int a);
		i_nsspr_host.rd(a[11:0], got);
		chk(got, mdl.exists(a) ? mdl[a] : 0);
	endtask
	task automatic wrm(input int a, input int d);
		i_nsspr_host.wr(a[11:0], d[7:0]);
		if (msk.exists(a)) mdl[a] = d & msk[a];
	endtask
	task automatic outchk;
		chk({receiver_master_powerdown_o, lane_powerdown_o, sync_output0_powerdown_o,
			sync_output1_powerdown_o, lane_recovery_reset_release_o, serdes_config_addr_o,
			serdes_config_data_o}, {mdl[12'h200][0], mdl[12'h201][7:0], mdl[12'h203][1:0],
			mdl[12'h206][0], mdl[12'h210][7:0], mdl[12'h216][7:0]});
	endtask
	task automatic wait_load;
		for (int n = 0; n < 6 && ftw_load_o === 2'b00; n++) begin
			@(posedge clock_i);
			#1;
		end
	endtask
	task automatic wrap_up;
		if (bad_count == 0 && checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	// A hang is cut short well past the expected few hundred cycles.
	initial begin
		#50000;
		bad_count++;
		wrap_up();
	end

	//////////////////////////////////////////////////////////////////
	// Main sequence.
	initial begin
		int a;
		foreach (adr[i]) begin
			mdl[adr[i]] = rsv[i];
			msk[adr[i]] = mk[i];
		end
		repeat (6) @(posedge clock_i);
		#1;
		rst_n_i = 1'b1;
		outchk();
		foreach (adr[i]) rdchk(adr[i]);
		// Random writes with an unmapped address mixed in.
		for (int n = 0; n < 45; n++) begin
			a = (n % 9 == 8) ? 12'h2ff : adr[n % 9];
			wrm(a, $random(seed));
			outchk();
			rdchk(a);
		end
		// Commit strobes: address and data first, then a repeated lane strobe write that must not commit again.
		wrm(12'h212, 0);
		wrm(12'h213, 0);
		wrm(12'h210, 8'h5a);
		wrm(12'h216, 8'ha5);
		wrm(12'h212, 8'h81);
		@(posedge clock_i);
		#1;
		chk({serdes_lane_commit_o, serdes_config_addr_o, serdes_config_data_o}, 24'h815aa5);
		wrm(12'h212, 8'h81);
		@(posedge clock_i);
		#1;
		chk(serdes_lane_commit_o, 0);
		wrm(12'h213, 1);
		@(posedge clock_i);
		#1;
		chk(serdes_misc_commit_o, 1);
		// Oscillator sync from the start bit, then SYSREF, then rotation.
		i_nsspr_host.wr(12'h1e7, 8'h01);
		@(posedge clock_i);
		#1;
		chk(ftw_load_o, 2'b01);
		@(posedge clock_i);
		#1;
		chk({ftw_load_o, phase_sync_o}, 4'b0001);
		nco_loaded_i = 2'b01;
		// The ack sets one cycle after the loaded report is seen in the wait state.
		@(posedge clock_i);
		i_nsspr_host.rd(12'h1e7, got);
		chk(got, 8'h03);
		main_converter_page_select = 2'b10;
		trigger_is_sysref_i = 1'b1;
		sysref_i = 1'b1;
		wait_load();
		// SYSREF is device-wide: every idle converter starts, whatever the page.
		chk(ftw_load_o, 2'b11);
		nco_loaded_i = 2'b11;
		repeat (2) @(posedge clock_i);
		i_nsspr_host.rd(12'h1e7, got);
		chk(got, 8'h02);
		oscillator_reset_after_rotation = 1'b1;
		wait_load();
		chk(ftw_load_o, 2'b11);
		repeat (2) @(posedge clock_i);
		i_nsspr_host.rd(12'h1e7, got);
		chk(got, 8'h02);
		// Calibration mux per page.
		datapath_i = $random(seed);
		dc_value_i = 16'($random(seed));
		main_converter_page_select = 2'b01;
		i_nsspr_host.wr(12'h1e6, 8'h03);
		@(posedge clock_i);
		#1;
		chk({dds_in_o, cal_frequency_tune_enable_o}, {datapath_i[1], dc_value_i, 1'b1});
		main_converter_page_select = 2'b10;
		i_nsspr_host.wr(12'h1e6, 8'h03);
		@(posedge clock_i);
		#1;
		chk({dds_in_o, cal_frequency_tune_enable_o}, {dc_value_i, dc_value_i, 1'b1});
		i_nsspr_host.rd(12'h1e6, got);
		chk(got, 8'h02);
		main_converter_page_select = 2'b01;
		i_nsspr_host.wr(12'h1e6, 8'h00);
		@(posedge clock_i);
		#1;
		chk({dds_in_o, cal_frequency_tune_enable_o}, {dc_value_i, datapath_i[0], 1'b0});
		wrap_up();
	end
endmodule // tb_top
`default_nettype wire
